/* File: hdl/delay_channel.v */
// reprogramming delay counter and status gating for one output
`timescale 1ns/1ps
module delay_channel (
    input  wire        i_clk,
    input  wire        i_nrst,
    input  wire        i_tick,
    input  wire        i_restart,
    input  wire        i_set,
    input  wire [12:0] i_set_val,
    input  wire [3:0]  i_status,
    input  wire [3:0]  i_mask,
    output reg  [12:0] o_setting,
    output wire        o_masking,
    output wire [3:0]  o_gated,
    output reg  [3:0]  o_fault_set
);
`include "supply_settings_map.vh"
reg  [12:0] count;
reg  [3:0]  prev_st;
reg  [3:0]  prev_mask;
assign o_masking = (count != 13'h0000);
assign o_gated   = o_masking ? 4'h0 : i_status;
always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        o_setting   <= `DELAY_RESET_STEPS;
        count       <= 13'h0000;
        prev_st     <= 4'h0;
        prev_mask   <= 4'h0;
        o_fault_set <= 4'h0;
    end else begin
        if (i_set) begin
            o_setting <= i_set_val;
        end
        if (i_restart) begin
            count <= o_setting;
        end else if (i_tick && o_masking) begin
            count <= count - 13'h0001;
        end
        prev_st     <= o_gated;
        prev_mask   <= i_mask;
        o_fault_set <= i_mask & ((o_gated & ~prev_st) | (o_gated & ~prev_mask));
    end
end
endmodule // delay_channel

/* File: hdl/supply_settings_control.v */
// settings control: delays, address, error, store/recall, calibration gating
// Operation
// - hide regulation bits during delay
// - restart delay on setpoint commands
// - delay range 0-32 s, 4 ms
// - delay resets to 20 ms
// - bus address 0 to 30
// - bus address resets to 5
// - error lights indicator and poll bit
// - read shows error, then clears it
// - local display of error only local
// - ten slots store, recall all outputs
// - slots power up zero/minimum
// - store allowed while outputs disabled
// - calibration constants to nonvolatile memory
// - one channel per calibration sequence
// - separate overvoltage calibration command
// - protect jumper rejects calibration
// - channel number one to four; one to two while the ctrl channels bit is clear
// - calibration mode gates calibration commands
// - overvoltage cal after voltage, 10 s
// - fault on rise or unmask
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "supply_settings_map.vh"
module supply_settings_control #(
    parameter TICK_CYCLES   = `DELAY_TICK_CYCLES,
    parameter OV_CAL_CYCLES = `OV_CAL_CYCLES
) (
    input  wire        I_CLK,
    input  wire        I_NRST,
    input  wire [3:0]  I_ADDR,
    input  wire [15:0] I_WDATA,
    input  wire        I_WR,
    input  wire        I_RD,
    output reg  [15:0] O_RDATA,
    input  wire [3:0]  I_CMD_CHAN_SEL,
    input  wire        I_VOLTAGE_SETPOINT_CMD,
    input  wire        I_CURRENT_SETPOINT_CMD,
    input  wire        I_OVERVOLTAGE_RESET_CMD,
    input  wire        I_OVERCURRENT_RESET_CMD,
    input  wire        I_OUT_CMD,
    input  wire        I_SAVE_CMD,
    input  wire        I_RECALL_CMD,
    input  wire [3:0]  I_SLOT,
    input  wire [63:0] I_SETPOINTS,
    output reg  [63:0] O_RECALL_DATA,
    output reg         O_RECALL_VALID,
    input  wire [15:0] I_STATUS,
    output wire [15:0] O_STATUS_GATED,
    output reg  [15:0] O_FAULT_SET,
    input  wire        I_HW_ERROR,
    input  wire        I_CAL_PROTECT,
    input  wire        I_CAL_DONE,
    output reg         O_CAL_MODE,
    output reg         O_CAL_BUSY,
    output reg         O_NVM_WRITE,
    output reg  [2:0]  O_CAL_OP,
    output reg  [1:0]  O_CAL_CHAN,
    output reg  [4:0]  O_BUS_ADDR,
    output wire        O_ERR_LED,
    output wire        O_POLL_ERR,
    output reg  [3:0]  O_DISPLAY_ERR
);
// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
reg [1:0] prot_sync;
reg [1:0] hw_sync;
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        prot_sync <= 2'b00;
        hw_sync   <= 2'b00;
    end else begin
        prot_sync <= {prot_sync[0], I_CAL_PROTECT};
        hw_sync   <= {hw_sync[0], I_HW_ERROR};
    end
end
wire cal_protect = prot_sync[1];
reg  hw_prev;
// ------------------------------------------------------------
// register decode
// ------------------------------------------------------------
wire wr_ctrl   = I_WR && (I_ADDR == `REG_CTRL);
wire wr_addr   = I_WR && (I_ADDR == `REG_ADDR);
wire wr_dsel   = I_WR && (I_ADDR == `REG_DELAY_SEL);
wire wr_dval   = I_WR && (I_ADDR == `REG_DELAY_VAL);
wire wr_cal    = I_WR && (I_ADDR == `REG_CAL);
wire wr_mask   = I_WR && (I_ADDR == `REG_MASK_SEL);
wire rd_err    = I_RD && (I_ADDR == `REG_ERROR);
reg         local_mode;
reg         four_chans;
reg  [1:0]  delay_sel;
reg  [15:0] mask;
reg  [3:0]  err_code;
reg  [1:0]  cal_chan_done;
reg         volt_cal_ok;
// ------------------------------------------------------------
// delay tick
// ------------------------------------------------------------
reg  [19:0] tick_cnt;
wire        tick = (tick_cnt == 20'h00000);
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        tick_cnt <= 20'h00000;
    end else if (tick) begin
        tick_cnt <= TICK_CYCLES[19:0] - 20'h00001;
    end else begin
        tick_cnt <= tick_cnt - 20'h00001;
    end
end
// ------------------------------------------------------------
// per-output delay channels
// ------------------------------------------------------------
wire        any_cmd   = I_VOLTAGE_SETPOINT_CMD | I_CURRENT_SETPOINT_CMD | I_OVERVOLTAGE_RESET_CMD |
                        I_OVERCURRENT_RESET_CMD | I_OUT_CMD;
wire        delay_ok  = (I_WDATA[12:0] <= `DELAY_MAX_STEPS) && (I_WDATA[15:13] == 3'b000);
wire [3:0]  masking;
wire [51:0] settings;
wire [15:0] fault_bits;
genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : gen_chan
        // restart per output or on recall
        delay_channel u_delay (
            .i_clk       (I_CLK),
            .i_nrst      (I_NRST),
            .i_tick      (tick),
            .i_restart   ((any_cmd & I_CMD_CHAN_SEL[g]) | O_RECALL_VALID),
            .i_set       (wr_dval && delay_ok && (delay_sel == g)),
            .i_set_val   (I_WDATA[12:0]),
            .i_status    (I_STATUS[4*g+3:4*g]),
            .i_mask      (mask[4*g+3:4*g]),
            .o_setting   (settings[13*g+12:13*g]),
            .o_masking   (masking[g]),
            .o_gated     (O_STATUS_GATED[4*g+3:4*g]),
            .o_fault_set (fault_bits[4*g+3:4*g])
        );
    end
endgenerate
always @* O_FAULT_SET = fault_bits;
// ------------------------------------------------------------
// store/recall slots
// ------------------------------------------------------------
reg  [63:0] slots [0:9];
wire        slot_ok = (I_SLOT >= `SLOT_MIN) && (I_SLOT <= `SLOT_MAX);
wire [3:0]  slot_ix = I_SLOT - `SLOT_MIN;
integer k;
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        for (k = 0; k < 10; k = k + 1) begin
            slots[k] <= 64'h0000000000000000;
        end
        O_RECALL_DATA  <= 64'h0000000000000000;
        O_RECALL_VALID <= 1'b0;
    end else begin
        O_RECALL_VALID <= 1'b0;
        if (I_SAVE_CMD && slot_ok) begin
            slots[slot_ix] <= I_SETPOINTS;
        end
        if (I_RECALL_CMD && slot_ok) begin
            O_RECALL_DATA  <= slots[slot_ix];
            O_RECALL_VALID <= 1'b1;
        end
    end
end
// ------------------------------------------------------------
// calibration sequencer
// ------------------------------------------------------------
wire [2:0] cal_op    = I_WDATA[2:0];
wire [2:0] cal_ch    = I_WDATA[6:4];
wire [2:0] ch_limit  = four_chans ? `CHAN_MAX : 3'h2;
wire       ch_ok     = (cal_ch != 3'h0) && (cal_ch <= ch_limit);
wire       is_mode   = (cal_op == `CAL_OP_MODE);
wire       cal_accept = wr_cal && !cal_protect && !O_CAL_BUSY && (is_mode || (O_CAL_MODE && ch_ok));
wire       ov_seq_bad = (cal_op == `CAL_OP_OV_CAL) &&
                        !(volt_cal_ok && (cal_chan_done == cal_ch[1:0] - 2'h1));
reg  [31:0] busy_cnt;
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        O_CAL_MODE    <= 1'b0;
        O_CAL_BUSY    <= 1'b0;
        O_NVM_WRITE   <= 1'b0;
        O_CAL_OP      <= `CAL_OP_MODE;
        O_CAL_CHAN    <= 2'b00;
        cal_chan_done <= 2'b00;
        volt_cal_ok   <= 1'b0;
        busy_cnt      <= 32'h00000000;
    end else begin
        O_NVM_WRITE <= 1'b0;
        if (O_CAL_BUSY) begin
            // overvoltage cal up to 10 s
            busy_cnt <= busy_cnt - 32'h00000001;
            if (I_CAL_DONE || busy_cnt == 32'h00000000) begin
                O_CAL_BUSY <= 1'b0;
            end
        end else if (cal_accept && !ov_seq_bad) begin
            O_CAL_OP <= cal_op;
            if (is_mode) begin
                O_NVM_WRITE <= O_CAL_MODE && !I_WDATA[8];
                O_CAL_MODE  <= I_WDATA[8];
                volt_cal_ok <= 1'b0;
            end else begin
                O_CAL_CHAN    <= cal_ch[1:0] - 2'h1;
                cal_chan_done <= cal_ch[1:0] - 2'h1;
                // voltage cal of this channel first
                volt_cal_ok   <= (cal_op == `CAL_OP_VMEAS) ||
                                 (volt_cal_ok && (cal_chan_done == cal_ch[1:0] - 2'h1));
                if (cal_op == `CAL_OP_OV_CAL) begin
                    O_CAL_BUSY <= 1'b1;
                    busy_cnt   <= OV_CAL_CYCLES[31:0];
                end
            end
        end
    end
end
// ------------------------------------------------------------
// control, address and error registers
// ------------------------------------------------------------
wire cal_reject = wr_cal && !(cal_accept && !ov_seq_bad);
reg  [3:0] next_err;
always @* begin
    next_err = err_code;
    if (rd_err) begin
        next_err = `ERR_NONE;
    end
    if ((wr_addr && I_WDATA[4:0] > `ADDR_MAX) || (wr_addr && I_WDATA[15:5] != 11'h000) ||
        (wr_dval && !delay_ok) || ((I_SAVE_CMD || I_RECALL_CMD) && !slot_ok)) begin
        next_err = `ERR_RANGE;
    end else if (cal_reject) begin
        next_err = cal_protect ? `ERR_CAL_LOCK : `ERR_CAL_SEQ;
    end else if (hw_sync[1] && !hw_prev) begin
        next_err = `ERR_HW;
    end
end
always @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
        local_mode    <= 1'b1;
        four_chans    <= 1'b1;
        delay_sel     <= 2'b00;
        mask          <= 16'h0000;
        O_BUS_ADDR    <= `ADDR_RESET;
        err_code      <= `ERR_NONE;
        hw_prev       <= 1'b0;
        O_DISPLAY_ERR <= `ERR_NONE;
        O_RDATA       <= 16'h0000;
    end else begin
        hw_prev  <= hw_sync[1];
        err_code <= next_err;
        if (wr_ctrl) begin
            local_mode <= I_WDATA[`CTRL_LOCAL_BIT];
            four_chans <= I_WDATA[`CTRL_CHANS_BIT];
        end
        if (wr_addr && I_WDATA[15:0] <= {11'h000, `ADDR_MAX}) begin
            O_BUS_ADDR <= I_WDATA[4:0];
        end
        if (wr_dsel) begin
            delay_sel <= I_WDATA[1:0];
        end
        if (wr_mask) begin
            mask <= I_WDATA;
        end
        if (rd_err && local_mode) begin
            O_DISPLAY_ERR <= err_code;
        end
        O_RDATA <= 16'h0000;
        if (I_RD) begin
            case (I_ADDR)
                `REG_CTRL:      O_RDATA <= {14'h0000, four_chans, local_mode};
                `REG_ADDR:      O_RDATA <= {11'h000, O_BUS_ADDR};
                `REG_DELAY_SEL: O_RDATA <= {14'h0000, delay_sel};
                `REG_DELAY_VAL: O_RDATA <= {3'h0, settings[13*delay_sel +: 13]};
                `REG_ERROR:     O_RDATA <= {12'h000, err_code};
                `REG_STATUS:    O_RDATA <= {8'h00, masking, 1'b0, (err_code != `ERR_NONE), O_CAL_BUSY, O_CAL_MODE};
                `REG_CAL:       O_RDATA <= {11'h000, O_CAL_CHAN, O_CAL_OP};
                `REG_MASK_SEL:  O_RDATA <= mask;
                default:        O_RDATA <= 16'h0000;
            endcase
        end
    end
end
assign O_ERR_LED  = (err_code != `ERR_NONE);
assign O_POLL_ERR = O_ERR_LED;
endmodule // supply_settings_control

/* File: hdl/supply_settings_map.vh */
// constants for the supply settings control block
`ifndef SUPPLY_SETTINGS_MAP_VH
`define SUPPLY_SETTINGS_MAP_VH
// timing
`define CLK_PERIOD_NS        5
`define DELAY_TICK_MS        4
`define DELAY_TICK_CYCLES    (`DELAY_TICK_MS * 1000000 / `CLK_PERIOD_NS)
`define DELAY_MAX_MS         32000
`define DELAY_MAX_STEPS      13'h1F40
`define DELAY_RESET_MS       20
`define DELAY_RESET_STEPS    13'h0005
`define OV_CAL_MAX_S         10
`define OV_CAL_CYCLES        (`OV_CAL_MAX_S * (1000000000 / `CLK_PERIOD_NS))
// ranges
`define ADDR_MAX             5'h1E
`define ADDR_RESET           5'h05
`define SLOT_MIN             4'h1
`define SLOT_MAX             4'hA
`define CHAN_MAX             3'h4
// register offsets
`define REG_CTRL             4'h0
`define REG_ADDR             4'h1
`define REG_DELAY_SEL        4'h2
`define REG_DELAY_VAL        4'h3
`define REG_ERROR            4'h4
`define REG_STATUS           4'h5
`define REG_CAL              4'h6
`define REG_MASK_SEL         4'h7
// ctrl fields
`define CTRL_LOCAL_BIT       0
`define CTRL_CHANS_BIT       1
// status fields
`define ST_CAL_MODE_BIT      0
`define ST_CAL_BUSY_BIT      1
`define ST_ERR_BIT           2
`define ST_MASKING_LSB       4
// error codes
`define ERR_NONE             4'h0
`define ERR_RANGE            4'h1
`define ERR_HW               4'h2
`define ERR_CAL_LOCK         4'h3
`define ERR_CAL_SEQ          4'h4
// calibration opcodes
`define CAL_OP_MODE          3'h0
`define CAL_OP_VMEAS         3'h1
`define CAL_OP_IMEAS         3'h2
`define CAL_OP_OV_CAL        3'h3
`define CAL_OP_POINT         3'h4
`endif

/* File: verification/bus_controller_model.sv */
// bus controller model driving the register bus
`timescale 1ns/1ps
module bus_controller_model (
    input  wire logic   i_clk,
    input  wire logic   i_busy,
    output logic [3:0]  o_addr = 4'h0,
    output logic [15:0] o_wdata = 16'h0000,
    output logic        o_wr = 1'b0,
    output logic        o_rd = 1'b0
);
    // released lines show the inverse of the last value
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
    endtask
    task automatic cal(input logic [2:0] op, input logic [2:0] ch, input logic m);
        if (op == 3'h0 || (ch != 3'h0 && ch <= 3'h4)) wr(4'h6, {7'h00, m, 1'b0, ch, 1'b0, op});
    endtask
    task automatic wait_idle(output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 200 && !ok; n++) begin
            @(posedge i_clk);
            ok = !i_busy;
        end
    endtask
endmodule // bus_controller_model

/* File: verification/supply_settings_checker_asserts.sv */
// port assertions for the supply settings control block
`timescale 1ns/1ps
module supply_settings_checker #(
    parameter OV_CAL_CYCLES = 50
) (
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_RD,
    input wire logic I_RECALL_CMD,
    input wire logic I_CAL_PROTECT,
    input wire logic [15:0] I_STATUS,
    input wire logic O_RECALL_VALID,
    input wire logic [15:0] O_STATUS_GATED,
    input wire logic [15:0] O_FAULT_SET,
    input wire logic O_CAL_MODE,
    input wire logic O_CAL_BUSY,
    input wire logic O_NVM_WRITE,
    input wire logic [4:0] O_BUS_ADDR,
    input wire logic O_ERR_LED,
    input wire logic O_POLL_ERR,
    input wire logic [3:0] O_DISPLAY_ERR
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    int busy_cnt;
    // ----
    // busy length counter
    // ----
    always @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) busy_cnt <= 0;
        else busy_cnt <= O_CAL_BUSY ? busy_cnt + 1 : 0;
    end
    addr_range_a: assert property (O_BUS_ADDR <= 5'h1E)
        else $error("bus address above limit");
    err_flags_a: assert property (O_ERR_LED == O_POLL_ERR)
        else $error("error lamp and poll bit differ");
    gated_subset_a: assert property ((O_STATUS_GATED & ~I_STATUS) == 16'h0000)
        else $error("gated status not from status");
    fault_cause_a: assert property (|O_FAULT_SET |-> (O_FAULT_SET & ~$past(O_STATUS_GATED)) == 16'h0000)
        else $error("fault without gated status");
    recall_source_a: assert property (O_RECALL_VALID |-> $past(I_RECALL_CMD) ##1 !O_RECALL_VALID)
        else $error("recall pulse without command");
    nvm_exit_a: assert property (O_NVM_WRITE |-> !O_CAL_MODE ##1 !O_NVM_WRITE)
        else $error("store pulse outside mode exit");
    busy_in_mode_a: assert property (O_CAL_BUSY |-> O_CAL_MODE)
        else $error("busy outside calibration mode");
    busy_bound_a: assert property (busy_cnt <= OV_CAL_CYCLES + 2)
        else $error("calibration busy too long");
    protect_lock_a: assert property ($rose(O_CAL_MODE) |-> !$past(I_CAL_PROTECT, 3))
        else $error("mode entered while protected");
    display_read_a: assert property (!$stable(O_DISPLAY_ERR) |-> $past(I_RD) || $past(I_RD, 2))
        else $error("display changed without read");
endmodule // supply_settings_checker
bind supply_settings_control supply_settings_checker #(.OV_CAL_CYCLES(OV_CAL_CYCLES)) u_chk (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_RD(I_RD), .I_RECALL_CMD(I_RECALL_CMD),
    .I_CAL_PROTECT(I_CAL_PROTECT), .I_STATUS(I_STATUS), .O_RECALL_VALID(O_RECALL_VALID),
    .O_STATUS_GATED(O_STATUS_GATED), .O_FAULT_SET(O_FAULT_SET), .O_CAL_MODE(O_CAL_MODE),
    .O_CAL_BUSY(O_CAL_BUSY), .O_NVM_WRITE(O_NVM_WRITE), .O_BUS_ADDR(O_BUS_ADDR),
    .O_ERR_LED(O_ERR_LED), .O_POLL_ERR(O_POLL_ERR), .O_DISPLAY_ERR(O_DISPLAY_ERR));

/* File: verification/supply_settings_control_test.sv */
// self-checking bench for the supply settings control block
`timescale 1ns/1ps
`include "supply_settings_map.vh"
module supply_settings_control_test;
    logic        clk, nrst, wr, rd, sav, recall, hw, prot, done, busy, rd_d, ok;
    logic        rvalid, cal_mode, nvm, led, perr;
    logic [4:0]  cmd, badr;
    logic [3:0]  addr, sel, slot, derr;
    logic [2:0]  cop;
    logic [1:0]  cch;
    logic [15:0] wdata, rdata, status, gated, fault, f_acc;
    logic [63:0] setp, rdat, rcap, exp_rc;
    logic [15:0] expq[$];
    logic [31:0] seed;
    int          fail_count, n_checks, n_nvm, n_rv, n;
    supply_settings_control #(.TICK_CYCLES(4), .OV_CAL_CYCLES(50)) u_dut (
        .I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .I_CMD_CHAN_SEL(sel), .I_VOLTAGE_SETPOINT_CMD(cmd[0]),
        .I_CURRENT_SETPOINT_CMD(cmd[1]), .I_OVERVOLTAGE_RESET_CMD(cmd[2]),
        .I_OVERCURRENT_RESET_CMD(cmd[3]), .I_OUT_CMD(cmd[4]), .I_SAVE_CMD(sav),
        .I_RECALL_CMD(recall), .I_SLOT(slot), .I_SETPOINTS(setp), .O_RECALL_DATA(rdat),
        .O_RECALL_VALID(rvalid), .I_STATUS(status), .O_STATUS_GATED(gated), .O_FAULT_SET(fault),
        .I_HW_ERROR(hw), .I_CAL_PROTECT(prot), .I_CAL_DONE(done), .O_CAL_MODE(cal_mode),
        .O_CAL_BUSY(busy), .O_NVM_WRITE(nvm), .O_CAL_OP(cop), .O_CAL_CHAN(cch),
        .O_BUS_ADDR(badr), .O_ERR_LED(led), .O_POLL_ERR(perr), .O_DISPLAY_ERR(derr));
    bus_controller_model u_host (.i_clk(clk), .i_busy(busy), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic rdx(input logic [3:0] a, input logic [15:0] e);
        expq.push_back(e);
        u_host.rd(a);
    endtask
    task automatic pulse_cmd(input int k, input logic [3:0] s);
        @(posedge clk);
        cmd <= 5'h01 << k;
        sel <= s;
        @(posedge clk);
        cmd <= 5'h00;
    endtask
    task automatic slot_cmd(input logic s_save, input logic [3:0] s);
        @(posedge clk);
        sav <= s_save;
        recall <= !s_save;
        slot <= s;
        @(posedge clk);
        sav <= 1'b0;
        recall <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----
    // output watcher
    // ----
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) chk(rdata, expq.pop_front());
        if (rvalid) rcap = rdat;
        n_rv += rvalid;
        n_nvm += nvm;
        f_acc = f_acc | fault;
    end
    initial begin
        {nrst, cmd, sel, sav, recall, slot, hw, prot, done} = '0;
        setp = 64'h0;
        status = 16'h0000;
        f_acc = 16'h0000;
        seed = 32'h000121B7;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        chk(badr, 5'h05);
        rdx(`REG_DELAY_VAL, 16'h0005);
        u_host.wr(`REG_ADDR, 16'h001E);
        u_host.wr(`REG_ADDR, 16'h001F);
        @(posedge clk);
        chk(badr, 5'h1E);
        chk({led, perr}, 2'b11);
        rdx(`REG_ERROR, 16'h0001);
        rdx(`REG_ERROR, 16'h0000);
        @(posedge clk);
        chk({led, perr}, 2'b00);
        $display("address and error test done");
        u_host.wr(`REG_DELAY_VAL, 16'h1F40);
        u_host.wr(`REG_DELAY_VAL, 16'h1F41);
        rdx(`REG_DELAY_VAL, 16'h1F40);
        rdx(`REG_ERROR, 16'h0001);
        repeat (2) @(posedge clk);
        chk(derr, 4'h1);
        u_host.wr(`REG_CTRL, 16'h0002);
        u_host.cal(`CAL_OP_VMEAS, 3'h1, 1'b0);
        rdx(`REG_ERROR, 16'h0004);
        repeat (2) @(posedge clk);
        chk(derr, 4'h1);
        u_host.wr(`REG_CTRL, 16'h0003);
        $display("delay range and display test done");
        for (int g = 0; g < 4; g++) begin
            u_host.wr(`REG_DELAY_SEL, 16'(g));
            u_host.wr(`REG_DELAY_VAL, 16'h0003);
        end
        status <= 16'hFFFF;
        for (int k = 0; k < 5; k++) begin
            pulse_cmd(k, 4'h1 << (k % 4));
            repeat (8) @(posedge clk);
            chk(gated, 16'(~(16'h000F << (4 * (k % 4)))));
            for (n = 0; n < 8 && gated !== 16'hFFFF; n++) @(posedge clk);
            chk(n < 8, 1'b1);
            if (n == 8) finish_test;
        end
        f_acc = 16'h0000;
        u_host.wr(`REG_MASK_SEL, 16'h0010);
        repeat (3) @(posedge clk);
        chk(f_acc, 16'h0010);
        f_acc = 16'h0000;
        pulse_cmd(0, 4'h2);
        repeat (6) @(posedge clk);
        chk(f_acc, 16'h0000);
        for (n = 0; n < 8 && gated !== 16'hFFFF; n++) @(posedge clk);
        chk(n < 8, 1'b1);
        repeat (2) @(posedge clk);
        chk(f_acc, 16'h0010);
        hw <= 1'b1;
        repeat (4) @(posedge clk);
        chk(led, 1'b1);
        rdx(`REG_ERROR, 16'h0002);
        hw <= 1'b0;
        $display("masking and fault test done");
        prot <= 1'b1;
        repeat (3) @(posedge clk);
        u_host.cal(`CAL_OP_MODE, 3'h0, 1'b1);
        rdx(`REG_ERROR, 16'h0003);
        chk(cal_mode, 1'b0);
        prot <= 1'b0;
        repeat (3) @(posedge clk);
        u_host.cal(`CAL_OP_MODE, 3'h0, 1'b1);
        u_host.cal(`CAL_OP_OV_CAL, 3'h2, 1'b0);
        rdx(`REG_ERROR, 16'h0004);
        u_host.cal(`CAL_OP_VMEAS, 3'h2, 1'b0);
        u_host.cal(`CAL_OP_OV_CAL, 3'h2, 1'b0);
        @(posedge clk);
        chk({cal_mode, busy, cop, cch}, {2'b11, `CAL_OP_OV_CAL, 2'h1});
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        u_host.wait_idle(ok);
        chk(ok, 1'b1);
        if (!ok) finish_test;
        n_nvm = 0;
        u_host.cal(`CAL_OP_MODE, 3'h0, 1'b0);
        repeat (3) @(posedge clk);
        chk({n_nvm[1:0], cal_mode}, 3'b010);
        $display("calibration test done");
        slot_cmd(1'b0, 4'h3);
        chk(rcap, 64'h0);
        seed = lfsr(seed);
        exp_rc = {seed, lfsr(seed)};
        setp <= exp_rc;
        slot_cmd(1'b1, 4'hA);
        setp <= ~exp_rc;
        slot_cmd(1'b0, 4'h0);
        slot_cmd(1'b0, 4'hB);
        rdx(`REG_ERROR, 16'h0001);
        slot_cmd(1'b0, 4'hA);
        chk(rcap, exp_rc);
        chk(n_rv, 2);
        chk(gated, 16'h0000);
        $display("store and recall test done");
        finish_test;
    end
endmodule // supply_settings_control_test
